// ===== pswfc_core.sv
// forwarding core of a three-port switch: port 0 upstream, 1 and 2 down
// assumes link layers deliver whole packets as word streams with sideband
// headers at sop, and acknowledge transmitted words back for replay release
`timescale 1ns/1ps
module pswfc_core #(
  parameter int QDEPTH    = pswfc_pkg::QDEPTH,
  parameter int RPL_DEPTH = pswfc_pkg::RPL_DEPTH
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // ingress streams
  input  wire logic [2:0]            in_valid,
  output logic      [2:0]            in_ready,
  input  wire logic [2:0][31:0]      in_data,
  input  wire logic [2:0]            in_sop,
  input  wire logic [2:0]            in_eop,
  input  wire logic [2:0][2:0]       in_tc,
  input  wire logic [2:0]            in_id_route,
  input  wire logic [2:0][31:0]      in_addr,
  input  wire logic [2:0][15:0]      in_dest_id,
  input  wire logic [2:0]            in_translated,
  // egress streams
  output logic      [2:0]            eg_valid,
  input  wire logic [2:0]            eg_ready,
  output logic      [2:0][31:0]      eg_data,
  output logic      [2:0]            eg_sop,
  output logic      [2:0]            eg_eop,
  output logic      [2:0]            eg_vc,
  input  wire logic [2:0]            eg_ack_valid,
  input  wire logic [2:0][7:0]       eg_ack_words,
  // enumeration and routing setup
  input  wire logic [2:0][7:0]       port_bus,
  input  wire logic [2:0][4:0]       port_dev,
  input  wire logic [2:0][2:0]       port_fn,
  input  wire logic [2:0][31:0]      dn_mem_base,
  input  wire logic [2:0][31:0]      dn_mem_limit,
  input  wire logic [2:0][7:0]       dn_sec_bus,
  input  wire logic [2:0][7:0]       dn_sub_bus,
  input  wire logic [2:0]            acs_redirect,
  input  wire logic [2:0]            acs_direct_xlat,
  // channel and arbitration setup
  input  wire logic                  vc1_enable,
  input  wire logic [2:0][7:0]       tc_vc1_map,
  input  wire logic [1:0]            parb_mode,
  input  wire logic [1:0]            vcarb_mode,
  input  wire logic [2:0][3:0]       port_weight,
  input  wire logic [1:0][3:0]       vc_weight,
  input  wire logic [7:0][1:0]       slot_owner,
  input  wire logic [3:0]            iso_budget,
  // pins
  input  wire logic [2:0]            dn_link_up,
  input  wire logic                  sf_mode_strap,
  // status
  output logic      [2:0][15:0]      port_dest_id,
  output logic      [2:0][8:0]       credit_vc0,
  output logic      [2:0][8:0]       credit_vc1,
  output logic      [2:0]            dn_idle,
  output logic                       sf_mode
);
  localparam int NP  = pswfc_pkg::NPORT;
  localparam int EW  = pswfc_pkg::ENTRY_W;
  localparam int QAW = $clog2(QDEPTH);
  localparam int RW  = $clog2(RPL_DEPTH) + 1;
  localparam int DL  = pswfc_pkg::E_DEST_LSB;

  pswfc_q_if #(.W(EW), .AW(QAW)) iq [NP] ();

  wire  [2:0][1:0]         hv;
  wire  [2:0][1:0][EW-1:0] hw;
  wire  [2:0][1:0][QAW:0]  hpk;
  wire  [2:0][2:0][1:0]    pop_m;
  logic [2:0]              link_m;
  logic [2:0]              link_s;
  logic [2:0][15:0]        port_id_c;
  logic                    strap_m;
  logic                    strap_s;
  logic [1:0]              arm;
  logic                    sf_held;
  logic [$clog2(pswfc_pkg::SLOT_CYC+1)-1:0] div_cnt;
  logic                    slot_tick;
  logic [pswfc_pkg::SLOT_W-1:0] slot;
  logic                    window_start;

  function automatic logic [1:0] rr_next(input logic [2:0] req,
                                         input logic [1:0] last);
    logic [1:0] c;
    logic [1:0] r;
    r = last;
    for (int k = NP; k >= 1; k--) begin
      c = 2'((int'(last) + k) % NP);
      if (req[c]) begin
        r = c;
      end
    end
    return r;
  endfunction : rr_next

  // pins cross into clk_sys through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_m  <= '0;
      link_s  <= '0;
      strap_m <= 1'b0;
      strap_s <= 1'b0;
    end else begin
      link_m  <= dn_link_up;
      link_s  <= link_m;
      strap_m <= sf_mode_strap;
      strap_s <= strap_m;
    end
  end

  // mode caught once the strap sync has filled, then frozen
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arm     <= '0;
      sf_held <= 1'b0;
    end else if (arm != 2'h3) begin
      arm     <= arm + 2'h1;
      sf_held <= strap_s;
    end
  end
  assign sf_mode = sf_held;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      slot    <= '0;
    end else if (slot_tick) begin
      div_cnt <= '0;
      slot    <= slot + 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign slot_tick    = (int'(div_cnt) == pswfc_pkg::SLOT_CYC - 1);
  assign window_start = slot_tick && (int'(slot) == pswfc_pkg::NSLOT - 1);

  always_comb begin
    for (int q = 0; q < NP; q++) begin
      port_id_c[q] = {port_bus[q], port_dev[q], port_fn[q]};
    end
  end

  for (genvar p = 0; p < NP; p++) begin : g_in
    logic       ready_q;
    logic       idle_q;
    logic [1:0] dest_q;
    logic       vc_q;
    logic [1:0] dest_c;
    logic       vc_c;
    logic [1:0] dest_w;
    logic [2:0] match;
    logic       self_id;
    logic [15:0] id_q;
    logic [8:0] cr0;
    logic [8:0] cr1;

    always_comb begin
      match   = '0;
      self_id = 1'b0;
      for (int q = 1; q < NP; q++) begin
        if (in_id_route[p]) begin
          match[q] = (in_dest_id[p][15:8] >= dn_sec_bus[q]) &&
                     (in_dest_id[p][15:8] <= dn_sub_bus[q]);
        end else begin
          match[q] = (in_addr[p] >= dn_mem_base[q]) &&
                     (in_addr[p] <= dn_mem_limit[q]);
        end
      end
      for (int q = 0; q < NP; q++) begin
        if (in_id_route[p] && in_dest_id[p] == port_id_c[q]) begin
          self_id = 1'b1;
        end
      end
      // bridge's own config traffic is not forwarded
      if (self_id) begin
        dest_c = pswfc_pkg::DEST_DROP;
      end else if (p == pswfc_pkg::UP) begin
        dest_c = match[1] ? 2'h1 : match[2] ? 2'h2 : pswfc_pkg::DEST_DROP;
      end else if (match[(NP - p) % NP]) begin
        if (acs_redirect[p] && !(in_translated[p] && acs_direct_xlat[p]))
        begin
          dest_c = 2'(pswfc_pkg::UP);
        end else begin
          dest_c = 2'(NP - p);
        end
      end else if (match[p]) begin
        dest_c = pswfc_pkg::DEST_DROP;
      end else begin
        dest_c = 2'(pswfc_pkg::UP);
      end
      if (dest_c != 2'(pswfc_pkg::UP) && dest_c != pswfc_pkg::DEST_DROP &&
          !link_s[dest_c]) begin
        dest_c = pswfc_pkg::DEST_DROP;
      end
      vc_c = vc1_enable && (in_tc[p] != 3'h0) &&
             tc_vc1_map[p][in_tc[p]];
    end

    assign dest_w = in_sop[p] ? dest_c : dest_q;
    assign iq[p].vc1_en   = vc1_enable;
    assign iq[p].wr_valid = in_valid[p] && ready_q &&
                            (dest_w != pswfc_pkg::DEST_DROP);
    assign iq[p].wr_vc    = in_sop[p] ? vc_c : vc_q;
    assign iq[p].wr_word  = {dest_w, in_sop[p], in_eop[p], in_data[p]};
    assign iq[p].rd_pop   = pop_m[0][p] | pop_m[1][p] | pop_m[2][p];
    assign hv[p]  = iq[p].rd_valid;
    assign hw[p]  = iq[p].rd_word;
    assign hpk[p] = iq[p].pkts;

    pswfc_iqueue #(.DEPTH(QDEPTH), .W(EW)) u_q (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .q       (iq[p])
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        dest_q <= pswfc_pkg::DEST_DROP;
        vc_q   <= 1'b0;
      end else if (in_valid[p] && ready_q && in_sop[p]) begin
        dest_q <= dest_c;
        vc_q   <= vc_c;
      end
    end

    // one word of slack covers the write landing while ready is updated
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        ready_q <= 1'b0;
        cr0     <= '0;
        cr1     <= '0;
        id_q    <= '0;
        idle_q  <= 1'b0;
      end else begin
        ready_q <= (iq[p].free[0] > 1) &&
                   (!vc1_enable || iq[p].free[1] > 1);
        cr0     <= 9'(iq[p].free[0]);
        cr1     <= 9'(iq[p].free[1]);
        id_q    <= port_id_c[p];
        idle_q  <= (p != pswfc_pkg::UP) && !link_s[p];
      end
    end
    assign in_ready[p]     = ready_q;
    assign credit_vc0[p]   = cr0;
    assign credit_vc1[p]   = cr1;
    assign port_dest_id[p] = id_q;
    assign dn_idle[p]      = idle_q;
  end

  for (genvar e = 0; e < NP; e++) begin : g_eg
    pswfc_pkg::pswfc_eg_state_t st;
    logic [1:0]  src;
    logic        svc;
    logic [1:0]  last_src;
    logic        last_vc;
    logic [3:0]  pcnt;
    logic [3:0]  vcnt;
    logic [3:0]  iso_cnt;
    logic [RW-1:0] rpl_used;
    logic [2:0]  req0;
    logic [2:0]  req1;
    logic [2:0]  reqv;
    logic        pick_vc;
    logic [1:0]  pick;
    logic [1:0]  rr_pick;
    logic        grant;
    logic        room;
    logic        adv;
    logic        pop_e;
    logic        v_q;
    logic [31:0] d_q;
    logic        s_q;
    logic        e_q;
    logic        c_q;
    logic [EW-1:0] cur;

    assign room = (int'(rpl_used) + pswfc_pkg::MAX_PKT_WORDS <= RPL_DEPTH) &&
                  (e == pswfc_pkg::UP || link_s[e]);
    assign adv  = !v_q || eg_ready[e];
    assign cur  = hw[src][svc];
    assign pop_e = (st == pswfc_pkg::PSWFC_EG_BUSY) && adv && hv[src][svc];

    for (genvar i = 0; i < NP; i++) begin : g_pop
      assign pop_m[e][i] = {pop_e && src == i && svc,
                            pop_e && src == i && !svc};
    end

    always_comb begin
      for (int i = 0; i < NP; i++) begin
        for (int v = 0; v < 2; v++) begin
          // only a packet head that has fully arrived may start in sf mode
          if (i != e && hv[i][v] && hw[i][v][pswfc_pkg::E_SOP] &&
              hw[i][v][DL +: 2] == 2'(e) &&
              (!sf_held || hpk[i][v] != '0)) begin
            if (v == 0) req0[i] = 1'b1; else req1[i] = 1'b1;
          end else begin
            if (v == 0) req0[i] = 1'b0; else req1[i] = 1'b0;
          end
        end
      end
      if (iso_cnt == 4'h0) req1 = '0;
      case (vcarb_mode)
        pswfc_pkg::PSWFC_VARB_STRICT: pick_vc = |req1;
        pswfc_pkg::PSWFC_VARB_RR:
          pick_vc = (|req0 && |req1) ? !last_vc : |req1;
        pswfc_pkg::PSWFC_VARB_WRR:
          pick_vc = (|req0 && |req1) ?
                    ((vcnt < vc_weight[last_vc]) ? last_vc : !last_vc) :
                    |req1;
        default: pick_vc = |req1;
      endcase
      reqv    = pick_vc ? req1 : req0;
      rr_pick = rr_next(reqv, last_src);
      case (parb_mode)
        pswfc_pkg::PSWFC_PARB_RR: pick = rr_pick;
        pswfc_pkg::PSWFC_PARB_WRR:
          pick = (reqv[last_src] && pcnt < port_weight[last_src]) ?
                 last_src : rr_pick;
        pswfc_pkg::PSWFC_PARB_TWRR:
          pick = reqv[slot_owner[slot]] ? slot_owner[slot] : rr_pick;
        default: pick = rr_pick;
      endcase
      grant = (st == pswfc_pkg::PSWFC_EG_IDLE) && |reqv && room;
    end

    // locked to one source until its eop so packets stay whole
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        st  <= pswfc_pkg::PSWFC_EG_IDLE;
        src <= '0;
        svc <= 1'b0;
      end else begin
        case (st)
          pswfc_pkg::PSWFC_EG_IDLE: if (grant) begin
            st  <= pswfc_pkg::PSWFC_EG_BUSY;
            src <= pick;
            svc <= pick_vc;
          end
          pswfc_pkg::PSWFC_EG_BUSY: if (pop_e && cur[pswfc_pkg::E_EOP]) begin
            st <= pswfc_pkg::PSWFC_EG_IDLE;
          end
          default: st <= pswfc_pkg::PSWFC_EG_IDLE;
        endcase
      end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        last_src <= '0;
        last_vc  <= 1'b0;
        pcnt     <= '0;
        vcnt     <= '0;
      end else if (grant) begin
        last_src <= pick;
        last_vc  <= pick_vc;
        pcnt     <= (pick == last_src) ? pcnt + 4'h1 : 4'h1;
        vcnt     <= (pick_vc == last_vc) ? vcnt + 4'h1 : 4'h1;
      end
    end

    // budget refills each window; a late refill never lets a burst through
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        iso_cnt <= '0;
      end else if (window_start) begin
        iso_cnt <= iso_budget;
      end else if (grant && pick_vc) begin
        iso_cnt <= iso_cnt - 4'h1;
      end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        rpl_used <= '0;
      end else begin
        rpl_used <= rpl_used + RW'(pop_e) -
                    ((eg_ack_valid[e] && RW'(eg_ack_words[e]) <= rpl_used)
                     ? RW'(eg_ack_words[e]) : RW'(0));
      end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        v_q <= 1'b0;
        d_q <= '0;
        s_q <= 1'b0;
        e_q <= 1'b0;
        c_q <= 1'b0;
      end else if (adv) begin
        v_q <= pop_e;
        d_q <= cur[pswfc_pkg::E_DATA_LSB +: 32];
        s_q <= cur[pswfc_pkg::E_SOP];
        e_q <= cur[pswfc_pkg::E_EOP];
        c_q <= svc;
      end
    end
    assign eg_valid[e] = v_q;
    assign eg_data[e]  = d_q;
    assign eg_sop[e]   = s_q;
    assign eg_eop[e]   = e_q;
    assign eg_vc[e]    = c_q;
  end
endmodule : pswfc_core

// ===== pswfc_pkg.sv
// constants and types shared by the switch forwarding core and its queues
// assumes a single 10 MHz core clock and 32-bit packet words
package pswfc_pkg;
  localparam int NPORT             = 3;
  localparam int UP                = 0;
  localparam int DATA_W            = 32;
  localparam int QDEPTH            = 256;
  localparam int RPL_DEPTH         = 256;
  localparam int MAX_PAYLOAD_BYTES = 512;
  localparam int HDR_WORDS         = 4;
  localparam int MAX_PKT_WORDS     = MAX_PAYLOAD_BYTES / 4 + HDR_WORDS;
  localparam int ACK_W             = 8;
  localparam int WT_W              = 4;
  // queue entry layout: {dest, sop, eop, data}
  localparam int E_DATA_LSB        = 0;
  localparam int E_EOP             = 32;
  localparam int E_SOP             = 33;
  localparam int E_DEST_LSB        = 34;
  localparam int ENTRY_W           = 36;
  localparam logic [1:0] DEST_DROP = 2'h3;
  // time-based arbitration slots
  localparam int CLK_HZ            = 10_000_000;
  localparam int SLOT_NS           = 1000;
  localparam int SLOT_CYC          = (SLOT_NS * (CLK_HZ / 1_000_000)
                                      + 999) / 1000;
  localparam int NSLOT             = 8;
  localparam int SLOT_W            = 3;
  typedef enum logic [1:0] {
    PSWFC_PARB_RR, PSWFC_PARB_WRR, PSWFC_PARB_TWRR
  } pswfc_parb_t;
  typedef enum logic [1:0] {
    PSWFC_VARB_STRICT, PSWFC_VARB_RR, PSWFC_VARB_WRR
  } pswfc_varb_t;
  typedef enum logic {PSWFC_EG_IDLE, PSWFC_EG_BUSY} pswfc_eg_state_t;
endpackage : pswfc_pkg

// ===== pswfc_q_if.sv
// carrier between the forwarding core and one ingress queue
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface pswfc_q_if #(
  parameter int W  = 36,
  parameter int AW = 8
);
  logic                 wr_valid;
  logic                 wr_vc;
  logic [W-1:0]         wr_word;
  logic [1:0]           rd_pop;
  logic [1:0]           rd_valid;
  logic [1:0][W-1:0]    rd_word;
  logic [1:0][AW:0]     free;
  logic [1:0][AW:0]     pkts;
  logic                 vc1_en;
  modport core (output wr_valid, wr_vc, wr_word, rd_pop, vc1_en,
                input rd_valid, rd_word, free, pkts);
  modport queue (input wr_valid, wr_vc, wr_word, rd_pop, vc1_en,
                 output rd_valid, rd_word, free, pkts);
endinterface : pswfc_q_if

// ===== pswfc_iqueue.sv
// one ingress queue: two virtual-channel rings in one shared array
// assumes vc1_en only changes while both rings are empty
`timescale 1ns/1ps
module pswfc_iqueue #(
  parameter int DEPTH = pswfc_pkg::QDEPTH,
  parameter int W     = pswfc_pkg::ENTRY_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // core side
  pswfc_q_if.queue q
);
  localparam int AW   = $clog2(DEPTH);
  localparam int HALF = DEPTH / 2;

  logic [W-1:0]      mem [DEPTH];
  logic [1:0][AW-1:0] wptr;
  logic [1:0][AW-1:0] rptr;
  logic [1:0][AW-1:0] base;
  logic [1:0][AW:0]   cnt;
  logic [1:0][AW:0]   pk;
  logic [1:0][AW:0]   cap;
  logic [1:0]         wr;
  logic [1:0]         rd;

  // unused second channel lends its half to the first
  assign cap[0]  = q.vc1_en ? (AW+1)'(HALF) : (AW+1)'(DEPTH);
  assign cap[1]  = q.vc1_en ? (AW+1)'(HALF) : '0;
  assign base[0] = '0;
  assign base[1] = AW'(HALF);

  for (genvar v = 0; v < 2; v++) begin : g_vc
    logic wr_eop;
    logic rd_eop;
    assign wr[v] = q.wr_valid && (q.wr_vc == v) && (cnt[v] < cap[v]);
    assign rd[v] = q.rd_pop[v] && (cnt[v] != '0);
    assign wr_eop = wr[v] && q.wr_word[pswfc_pkg::E_EOP];
    assign rd_eop = rd[v] && q.rd_word[v][pswfc_pkg::E_EOP];
    assign q.rd_valid[v] = (cnt[v] != '0);
    assign q.rd_word[v]  = mem[base[v] + rptr[v]];
    assign q.free[v]     = cap[v] - cnt[v];
    assign q.pkts[v]     = pk[v];

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        wptr[v] <= '0;
        rptr[v] <= '0;
      end else begin
        if (wr[v]) begin
          wptr[v] <= ({1'b0, wptr[v]} == cap[v] - 1'b1) ? '0 : wptr[v] + 1'b1;
        end
        if (rd[v]) begin
          rptr[v] <= ({1'b0, rptr[v]} == cap[v] - 1'b1) ? '0 : rptr[v] + 1'b1;
        end
      end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        cnt[v] <= '0;
        pk[v]  <= '0;
      end else begin
        cnt[v] <= cnt[v] + (AW+1)'(wr[v]) - (AW+1)'(rd[v]);
        pk[v]  <= pk[v] + (AW+1)'(wr_eop) - (AW+1)'(rd_eop);
      end
    end
  end

  // storage carries no reset; contents are qualified by the counts
  always_ff @(posedge clk_sys) begin
    if (wr[0]) begin
      mem[base[0] + wptr[0]] <= q.wr_word;
    end else if (wr[1]) begin
      mem[base[1] + wptr[1]] <= q.wr_word;
    end
  end
endmodule : pswfc_iqueue

// ===== pswfc_sink.sv
// egress partner of one core port: takes words, may stall, acks replay
// assumes the egress stream of one port and the same core clock
`timescale 1ns/1ps
module pswfc_sink (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // stall request
  input  wire logic        slow,
  // egress stream
  input  wire logic        eg_valid,
  input  wire logic [31:0] eg_data,
  input  wire logic        eg_sop,
  input  wire logic        eg_eop,
  input  wire logic        eg_vc,
  output logic             eg_ready,
  output logic             ack_valid,
  output logic [7:0]       ack_words,
  // capture
  output logic [7:0]       rx_pkts,
  output logic [7:0]       rx_words,
  output logic [31:0]      rx_first,
  output logic             rx_vc
);
  logic [7:0] cnt;
  assign ack_words = rx_words;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {eg_ready, ack_valid, cnt, rx_pkts, rx_words} <= '0;
    end else begin
      // stalls every other cycle so held words are really exercised
      eg_ready  <= slow ? !eg_ready : 1'b1;
      ack_valid <= eg_valid && eg_ready && eg_eop;
      if (eg_valid && eg_ready) begin
        cnt <= eg_eop ? 8'h00 : cnt + 8'h01;
        if (eg_sop) begin
          {rx_first, rx_vc} <= {eg_data, eg_vc};
        end
        if (eg_eop) begin
          {rx_words, rx_pkts} <= {cnt + 8'h01, rx_pkts + 8'h01};
        end
      end
    end
  end
endmodule : pswfc_sink

// ===== pswfc_core_asserts.sv
// checker for the forwarding core: ids, idle ports, mode hold, framing
// assumes binding to pswfc_core, single clock domain
`timescale 1ns/1ps
module pswfc_core_asserts (
  // clock and reset
  input wire logic             clk_sys,
  input wire logic             rst_n,
  // watched ports
  input wire logic [2:0][7:0]  port_bus,
  input wire logic [2:0][4:0]  port_dev,
  input wire logic [2:0][2:0]  port_fn,
  input wire logic [2:0][15:0] port_dest_id,
  input wire logic [2:0]       dn_link_up,
  input wire logic [2:0]       dn_idle,
  input wire logic [2:0]       eg_valid,
  input wire logic [2:0]       eg_ready,
  input wire logic [2:0][31:0] eg_data,
  input wire logic [2:0]       eg_sop,
  input wire logic [2:0]       eg_eop,
  input wire logic             sf_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [2:0] cnt;
  logic [2:0] in_pkt;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt <= 3'h0;
    else if (cnt != 3'h7) cnt <= cnt + 3'h1;
  end
  property p_sf_hold;
    cnt == 3'h7 |-> $stable(sf_mode);
  endproperty
  a_sf_hold: assert property (p_sf_hold) else $error("mode moved");
  property p_idle_up;
    dn_idle[0] == 1'b0;
  endproperty
  a_idle_up: assert property (p_idle_up) else $error("up idle");
  for (genvar g = 0; g < 3; g++) begin : g_p
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) in_pkt[g] <= 1'b0;
      else if (eg_valid[g] && eg_ready[g]) in_pkt[g] <= !eg_eop[g];
    end
    property p_dest_id;
      1 |=> port_dest_id[g] == $past({port_bus[g], port_dev[g], port_fn[g]});
    endproperty
    a_dest_id: assert property (p_dest_id) else $error("bad id");
    property p_eg_hold;
      eg_valid[g] && !eg_ready[g] |=> eg_valid[g] && $stable(eg_data[g])
        && $stable(eg_sop[g]) && $stable(eg_eop[g]);
    endproperty
    a_eg_hold: assert property (p_eg_hold) else $error("word moved");
    property p_sop_start;
      eg_valid[g] && eg_sop[g] |-> !in_pkt[g];
    endproperty
    a_sop_start: assert property (p_sop_start) else $error("merge");
    property p_mid_pkt;
      eg_valid[g] && !eg_sop[g] |-> in_pkt[g];
    endproperty
    a_mid_pkt: assert property (p_mid_pkt) else $error("split");
    if (g != 0) begin : g_dn
      sequence s_down3;
        !dn_link_up[g] [*3];
      endsequence
      sequence s_up3;
        dn_link_up[g] [*3];
      endsequence
      property p_idle_set;
        s_down3 |=> dn_idle[g];
      endproperty
      a_idle_set: assert property (p_idle_set) else $error("not idle");
      property p_idle_clr;
        s_up3 |=> !dn_idle[g];
      endproperty
      a_idle_clr: assert property (p_idle_clr) else $error("idle");
    end
  end
endmodule : pswfc_core_asserts
bind pswfc_core pswfc_core_asserts i_chk (.clk_sys, .rst_n, .port_bus,
  .port_dev, .port_fn, .port_dest_id, .dn_link_up, .dn_idle, .eg_valid,
  .eg_ready, .eg_data, .eg_sop, .eg_eop, .sf_mode);

// ===== tb_pswfc_core.sv
// bench for the forwarding core: packets in, sink models out
// assumes pswfc_sink on every egress port and the bound checker
`timescale 1ns/1ps
module tb_pswfc_core;
  logic             clk_sys = 1'b0;
  logic             rst_n, vc1_enable, sf_mode_strap, sf_mode;
  logic [2:0]       in_valid, in_ready, in_sop, in_eop, in_id_route;
  logic [2:0]       in_translated, eg_valid, eg_ready, eg_sop, eg_eop, eg_vc;
  logic [2:0]       eg_ack_valid, acs_redirect, acs_direct_xlat;
  logic [2:0]       dn_link_up, dn_idle, slow, rx_vc;
  logic [2:0][31:0] in_data, in_addr, eg_data, dn_mem_base, dn_mem_limit;
  logic [2:0][31:0] rx_first;
  logic [2:0][15:0] in_dest_id, port_dest_id;
  logic [2:0][7:0]  eg_ack_words, port_bus, dn_sec_bus, dn_sub_bus;
  logic [2:0][7:0]  tc_vc1_map, rx_pkts, rx_words;
  logic [2:0][8:0]  credit_vc0, credit_vc1;
  logic [2:0][4:0]  port_dev;
  logic [2:0][3:0]  port_weight;
  logic [2:0][2:0]  in_tc, port_fn;
  logic [1:0][3:0]  vc_weight;
  logic [7:0][1:0]  slot_owner;
  logic [1:0]       parb_mode, vcarb_mode;
  logic [3:0]       iso_budget;
  int               err_count = 0;
  int               total_checks = 0;
  always #50 clk_sys = !clk_sys;
  pswfc_core i_dut (.clk_sys, .rst_n, .in_valid, .in_ready, .in_data, .in_sop,
    .in_eop, .in_tc, .in_id_route, .in_addr, .in_dest_id, .in_translated,
    .eg_valid, .eg_ready, .eg_data, .eg_sop, .eg_eop, .eg_vc, .eg_ack_valid,
    .eg_ack_words, .port_bus, .port_dev, .port_fn, .dn_mem_base,
    .dn_mem_limit, .dn_sec_bus, .dn_sub_bus, .acs_redirect, .acs_direct_xlat,
    .vc1_enable, .tc_vc1_map, .parb_mode, .vcarb_mode, .port_weight,
    .vc_weight, .slot_owner, .iso_budget, .dn_link_up, .sf_mode_strap,
    .port_dest_id, .credit_vc0, .credit_vc1, .dn_idle, .sf_mode);
  for (genvar g = 0; g < 3; g++) begin : g_sk
    pswfc_sink i_sk (.clk_sys, .rst_n, .slow(slow[g]),
      .eg_valid(eg_valid[g]), .eg_data(eg_data[g]), .eg_sop(eg_sop[g]),
      .eg_eop(eg_eop[g]), .eg_vc(eg_vc[g]), .eg_ready(eg_ready[g]),
      .ack_valid(eg_ack_valid[g]), .ack_words(eg_ack_words[g]),
      .rx_pkts(rx_pkts[g]), .rx_words(rx_words[g]),
      .rx_first(rx_first[g]), .rx_vc(rx_vc[g]));
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      err_count++;
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic xfer(input int s, input int d, input logic [31:0] a,
      input logic idr, input logic [15:0] id, input logic [2:0] tc,
      input int n, input logic [31:0] w, input logic v, input logic drop);
    logic [7:0] b;
    b = rx_pkts[d];
    {in_addr[s], in_id_route[s], in_dest_id[s], in_tc[s]} = {a, idr, id, tc};
    for (int k = 0; k < n; k++) begin
      {in_valid[s], in_sop[s], in_eop[s]} = {1'b1, k == 0, k == n - 1};
      in_data[s] = w + 32'(k);
      while (in_ready[s] !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
    end
    in_valid[s] = 1'b0;
    if (drop) begin
      repeat (60) @(negedge clk_sys);
      chk({24'h0, rx_pkts[d]}, {24'h0, b});
    end else begin
      for (int t = 0; t < 1000 && rx_pkts[d] === b; t++) @(negedge clk_sys);
      chk({24'h0, rx_words[d]}, 32'(n));
      chk(rx_first[d], w);
      chk({31'h0, rx_vc[d]}, {31'h0, v});
    end
  endtask : xfer
  task automatic do_reset(input logic strap);
    {rst_n, sf_mode_strap} = {1'b0, strap};
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask : do_reset
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    report_and_stop();
  end
  initial begin
    {in_valid, in_sop, in_eop, in_id_route, in_translated, slow} = '0;
    {in_data, in_addr, in_dest_id, in_tc, port_fn, slot_owner} = '0;
    {acs_redirect, acs_direct_xlat, parb_mode, vcarb_mode} = '0;
    {vc1_enable, iso_budget, dn_link_up, tc_vc1_map} =
      {1'b1, 4'hF, 3'h7, 24'hFFFFFF};
    {port_weight, vc_weight} = 20'h22222;
    port_bus = {8'h02, 8'h02, 8'h01};
    port_dev = {5'h02, 5'h01, 5'h00};
    dn_mem_base = {32'h2000_0000, 32'h1000_0000, 32'h0};
    dn_mem_limit = {32'h2FFF_FFFF, 32'h1FFF_FFFF, 32'h0};
    {dn_sec_bus, dn_sub_bus} = {2{8'h04, 8'h03, 8'h00}};
    do_reset(1'b0);
    for (int p = 0; p < 3; p++)
      chk(port_dest_id[p], {port_bus[p], port_dev[p], port_fn[p]});
    chk(sf_mode, 32'h0);
    chk(credit_vc0[1], 32'h80);
    chk(credit_vc1[2], 32'h80);
    chk({29'h0, in_ready}, 32'h7);
    $display("test ids done");
    for (int m = 0; m < 3; m++) begin
      {parb_mode, vcarb_mode} = {2'(m), 2'(m)};
      xfer(0, 1, 32'h1000_0040, 0, 0, 0, 4, 32'hA000_0000 + m,
           0, 0);
    end
    slow[2] = 1'b1;
    xfer(0, 2, 0, 1, 16'h0400, 3'h5, 132, 32'hB000_0000, 1, 0);
    slow[2] = 1'b0;
    xfer(1, 2, 32'h2000_0000, 0, 0, 3'h2, 2, 32'hC000_0000, 1, 0);
    xfer(2, 0, 32'h3000_0000, 0, 0, 0, 1, 32'hD000_0000, 0, 0);
    xfer(1, 0, 0, 1, 16'h0100, 0, 2, 32'hE000_0000, 0, 1);
    $display("test routing done");
    {acs_redirect[1], acs_direct_xlat[1]} = 2'h3;
    xfer(1, 0, 32'h2000_0100, 0, 0, 0, 3, 32'hF000_0000, 0, 0);
    in_translated[1] = 1'b1;
    xfer(1, 2, 32'h2000_0100, 0, 0, 0, 3, 32'hF100_0000, 0, 0);
    dn_link_up[2] = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(dn_idle[2], 32'h1);
    xfer(0, 2, 32'h2000_0000, 0, 0, 0, 2, 32'h1200_0000, 0, 1);
    dn_link_up[2] = 1'b1;
    vc1_enable = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(credit_vc0[0], 32'h100);
    chk(credit_vc1[0], 32'h0);
    $display("test access and idle done");
    do_reset(1'b1);
    sf_mode_strap = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(sf_mode, 32'h1);
    xfer(0, 1, 32'h1000_0000, 0, 0, 0, 8, 32'h5500_0000, 0, 0);
    $display("test store and forward done");
    report_and_stop();
  end
endmodule : tb_pswfc_core
